// ### soft_strap_consts.svh
// constant names for the soft strap latch: offsets, bit positions, reset values
`ifndef SOFT_STRAP_CONSTS_SVH
`define SOFT_STRAP_CONSTS_SVH
// register byte addresses on the bus
`define ADR_RESET_CTRL 8'h00
`define ADR_EEPROM_CMD 8'h04
`define ADR_LATCHED 8'h08
`define ADR_EFFECTIVE 8'h0C
// bit positions inside the command registers
`define BIT_DIGITAL_RST 0
`define BIT_RELOAD 0
`define BIT_EEPROM_OK 1
// tie-off values of straps without a pin
`define TIE_IND_FUN 2'h0
`define TIE_MAN_X 1'h0
`define TIE_AN 1'h1
`define TIE_SPEED 1'h1
`define TIE_DUPLEX 1'h1
// flop values while reset is applied
`define RST_IND_SEL 8'h00
`define RST_AUTO_X 1'h0
// phy mode field when negotiation is on
`define MODE_ALL_CAP 3'h7
// zero data word
`define WORD_ZERO 32'h0000_0000
`endif

// ### soft_strap_pkg.sv
// types shared by the soft strap latch and its ports
package soft_strap_pkg;
  // one complete set of soft strap values
  typedef struct packed {
    logic [7:0] ind_sel;  // indicator select bits, one per shared pin
    logic [1:0] ind_fun;  // indicator function bits
    logic auto_x;         // port 1 auto crossover enable
    logic man_x;          // port 1 manual crossover, 1 = crossed
    logic an;             // port 1 negotiation enable
  } strap_set_t;
  // phy register defaults derived from the straps
  typedef struct packed {
    logic an_en;     // negotiation enable bit
    logic rate;      // rate select bit, 1 = 100 Mbps
    logic duplex;    // duplex select bit, 1 = full
    logic adv_10f;   // advert bit 6, 10BASE-T full
    logic adv_10h;   // advert bit 5, 10BASE-T half
    logic [2:0] mode; // phy mode field
  } phy_default_t;
  // crossover control towards the port 1 phy
  typedef struct packed {
    logic auto_en;  // automatic MDI/MDI-X selection enabled
    logic force_x;  // forced MDI-X when automatic is off
  } mdix_ctrl_t;
  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
endpackage

// ### strap_sync.sv
// two flop synchroniser for pins entering the ref_clk domain
`timescale 1ns/1ps
module strap_sync #(
  parameter int W = 3
) (
  input wire logic ref_clk,          // system clock
  input wire logic rst_n,            // async reset, active low
  input wire logic [W-1:0] async_in, // raw pin levels
  output logic [W-1:0] sync_out      // levels safe to read
);
  // one pair of flops per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r; // first stage
      logic hold_r; // second stage
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          hold_r <= meta_r;
        end
      end
      assign sync_out[i] = hold_r;
    end
  endgenerate
endmodule

// ### soft_strap_latch.sv
// soft strap latch: capture, loader override, revert, and derived defaults
// What this block does
// - capture straps at reset release, then hold
// - loader values replace effective values when present
// - pinless straps latch tie-offs; values feed defaults
// - digital reset or reload without eeprom reverts
// - revert uses captured value, pins not re-sampled
// - indicator strap high selects indicator, low gpio
// - one pin sets all eight select bits
// - function strap sets function bits, tie-off zero
// - auto crossover strap applies only without override
// - manual crossover picks MDI or MDI-X, default 0
// - negotiation strap sets negotiation enable default
// - negotiation strap sets rate, duplex, advert, mode
// - digital reset restarts the eeprom loader
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "soft_strap_consts.svh"
module soft_strap_latch #(
  parameter logic [1:0] IND_FUN_TIE = `TIE_IND_FUN, // indicator function tie-off
  parameter logic MAN_X_TIE = `TIE_MAN_X,            // manual crossover tie-off
  parameter logic AN_TIE = `TIE_AN,                  // negotiation tie-off
  parameter logic SPEED_TIE = `TIE_SPEED,            // rate tie-off, used without negotiation
  parameter logic DUPLEX_TIE = `TIE_DUPLEX           // duplex tie-off, used without negotiation
) (
  input wire logic ref_clk,                           // 25 MHz system clock
  input wire logic rst_n,                             // power-on reset, async, active low
  input wire logic external_reset_n,                  // reset pin, active low, async
  input wire logic ind_en_pin,                        // indicator enable strap pin
  input wire logic auto_x_pin,                        // port 1 auto crossover strap pin
  input wire logic eeprom_valid_i,                    // eeprom attached and not erased
  input wire logic loader_wr_i,                       // loader write pulse
  input wire soft_strap_pkg::strap_set_t loader_dat_i, // loader strap values
  input wire logic crossover_override_bit,            // phy override of crossover control
  input wire soft_strap_pkg::wb_req_t wb_req_i,       // wishbone request
  output soft_strap_pkg::strap_set_t cfg_o,           // effective strap values
  output soft_strap_pkg::phy_default_t phy_def_o,     // port 1 phy register defaults
  output soft_strap_pkg::mdix_ctrl_t mdix_o,          // port 1 crossover control
  output logic loader_start_o,                        // one cycle loader start pulse
  output logic wb_ack_o,                              // wishbone ack
  output logic [31:0] wb_dat_o                        // wishbone read data
);
  import soft_strap_pkg::*;

  // synchronised pins
  logic [2:0] pin_s;       // {ext reset, indicator enable, auto crossover}
  logic ext_n_s;           // synced reset pin
  logic ind_en_s;          // synced indicator strap
  logic auto_x_s;          // synced crossover strap

  // capture control
  logic pending_r;         // capture still owed since last reset
  logic pending_nxt;       // next pending state
  wire capture = pending_r & ext_n_s; // release of power or pin reset

  // strap storage
  strap_set_t latched_r;   // value captured at reset release
  strap_set_t latched_nxt; // next latched value
  strap_set_t eff_r;       // effective value, loader may replace
  strap_set_t eff_nxt;     // next effective value
  strap_set_t sample_w;    // what a capture would store

  // bus side
  logic ack_r;             // ack flop
  logic [31:0] rdat_r;     // read data flop
  logic [31:0] rdat_nxt;   // read data mux
  logic start_r;           // loader start flop
  logic dig_rst_r;         // digital reset command pulse
  logic reload_r;          // reload command pulse

  // derived outputs
  phy_default_t phy_r;     // phy defaults flop
  phy_default_t phy_nxt;   // phy defaults next
  mdix_ctrl_t mdix_r;      // crossover flop
  mdix_ctrl_t mdix_nxt;    // crossover next

  // bring the pins into the clock domain
  strap_sync #(.W(3)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({external_reset_n, ind_en_pin, auto_x_pin}),
    .sync_out(pin_s)
  );
  assign ext_n_s = pin_s[2];
  assign ind_en_s = pin_s[1];
  assign auto_x_s = pin_s[0];

  // register decode, done once as a function
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    hit = (adr == reg_adr);
  endfunction

  // bus access phases
  wire req = wb_req_i.cyc & wb_req_i.stb;             // request present
  wire take = req & ~ack_r;                           // first edge of a request
  wire wr_fire = req & ack_r & wb_req_i.we & wb_req_i.sel[0]; // write edge
  wire wr_rst = wr_fire & hit(wb_req_i.adr, `ADR_RESET_CTRL) &
                wb_req_i.dat[`BIT_DIGITAL_RST];
  wire wr_rel = wr_fire & hit(wb_req_i.adr, `ADR_EEPROM_CMD) &
                wb_req_i.dat[`BIT_RELOAD];

  // revert request: digital reset or reload with no usable eeprom
  wire cmd = dig_rst_r | reload_r;
  wire revert = cmd & ~eeprom_valid_i;

  // pending is owed while the pin reset is held, cleared by capture
  assign pending_nxt = ~ext_n_s;

  // capture sample: one pin fans out to all eight select bits
  assign sample_w.ind_sel = {8{ind_en_s}};
  assign sample_w.ind_fun = IND_FUN_TIE;
  assign sample_w.auto_x = auto_x_s;
  assign sample_w.man_x = MAN_X_TIE;
  assign sample_w.an = AN_TIE;

  // latched copy changes only on capture, never on commands
  assign latched_nxt = capture ? sample_w : latched_r;

  // effective copy: capture, then loader write, then revert
  always_comb begin
    eff_nxt = eff_r;
    if (capture) begin
      eff_nxt = sample_w;
    end else if (pending_r) begin
      eff_nxt = eff_r; // no loader or command while reset pending
    end else if (loader_wr_i) begin
      eff_nxt = loader_dat_i;
    end else if (revert) begin
      eff_nxt = latched_r;
    end
  end

  // negotiation forces full capability defaults, else rate and duplex ties
  always_comb begin
    phy_nxt.an_en = eff_r.an;
    phy_nxt.rate = eff_r.an | SPEED_TIE;
    phy_nxt.duplex = eff_r.an | DUPLEX_TIE;
    phy_nxt.adv_10f = eff_r.an | (~SPEED_TIE & DUPLEX_TIE);
    phy_nxt.adv_10h = eff_r.an | (~SPEED_TIE & ~DUPLEX_TIE);
    phy_nxt.mode = eff_r.an ? `MODE_ALL_CAP : {1'b0, SPEED_TIE, DUPLEX_TIE};
  end

  // crossover straps only act while the override bit is clear
  assign mdix_nxt.auto_en = ~crossover_override_bit & eff_r.auto_x;
  assign mdix_nxt.force_x = ~crossover_override_bit & ~eff_r.auto_x &
                            eff_r.man_x;

  // read data mux; unmapped addresses read zero
  always_comb begin
    rdat_nxt = `WORD_ZERO;
    if (hit(wb_req_i.adr, `ADR_EEPROM_CMD)) begin
      rdat_nxt[`BIT_EEPROM_OK] = eeprom_valid_i;
    end else if (hit(wb_req_i.adr, `ADR_LATCHED)) begin
      rdat_nxt[$bits(strap_set_t)-1:0] = latched_r;
    end else if (hit(wb_req_i.adr, `ADR_EFFECTIVE)) begin
      rdat_nxt[$bits(strap_set_t)-1:0] = eff_r;
    end
  end

  // capture bookkeeping
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_r <= 1'b1;
    end else begin
      pending_r <= pending_nxt;
    end
  end

  // latched and effective strap pairs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_r <= {`RST_IND_SEL, `TIE_IND_FUN, `RST_AUTO_X, `TIE_MAN_X, `TIE_AN};
      eff_r <= {`RST_IND_SEL, `TIE_IND_FUN, `RST_AUTO_X, `TIE_MAN_X, `TIE_AN};
    end else begin
      latched_r <= latched_nxt;
      eff_r <= eff_nxt;
    end
  end

  // bus handshake: ack one cycle after the request, dropped after one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rdat_r <= `WORD_ZERO;
    end else begin
      ack_r <= take;
      rdat_r <= take ? rdat_nxt : `WORD_ZERO;
    end
  end

  // command pulses and loader restart
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dig_rst_r <= 1'b0;
      reload_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      dig_rst_r <= wr_rst;
      reload_r <= wr_rel;
      start_r <= dig_rst_r;
    end
  end

  // derived outputs registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_r <= '0;
      mdix_r <= '0;
    end else begin
      phy_r <= phy_nxt;
      mdix_r <= mdix_nxt;
    end
  end

  assign cfg_o = eff_r;
  assign phy_def_o = phy_r;
  assign mdix_o = mdix_r;
  assign loader_start_o = start_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // checks, all on the system clock and quiet while power-on reset is low
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // capture stores the synced pins and copies them into the effective straps
  property p_capture;
    capture |=> (latched_r == $past(sample_w)) && (eff_r == latched_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  // commands and loader writes never touch the latched copy
  property p_hold;
    !capture |=> $stable(latched_r);
  endproperty
  a_hold: assert property (p_hold) else $error("latched value moved");

  // nothing moves the effective straps while a capture is still owed
  property p_pend_freeze;
    (pending_r && !capture) |=> $stable(eff_r);
  endproperty
  a_pend_freeze: assert property (p_pend_freeze) else $error("straps moved in reset");

  // a loader write replaces the effective straps in the next cycle
  property p_loader;
    (loader_wr_i && !pending_r) |=> (eff_r == $past(loader_dat_i));
  endproperty
  a_loader: assert property (p_loader) else $error("loader write lost");

  // a command with no usable eeprom falls back to the latched copy
  property p_revert;
    (revert && !loader_wr_i && !pending_r) |=> (eff_r == latched_r);
  endproperty
  a_revert: assert property (p_revert) else $error("revert wrong");

  // with a usable eeprom a command leaves the effective straps alone
  property p_keep;
    (cmd && eeprom_valid_i && !loader_wr_i && !pending_r) |=> $stable(eff_r);
  endproperty
  a_keep: assert property (p_keep) else $error("command reverted with eeprom");

  // pinless function and manual crossover straps take their tie-off values at capture
  property p_tie;
    capture |=> (latched_r.ind_fun == IND_FUN_TIE) && (latched_r.man_x == MAN_X_TIE);
  endproperty
  a_tie: assert property (p_tie) else $error("tie-off wrong");

  // the one indicator pin fans out to all eight select bits
  property p_sel_all;
    capture |=> (latched_r.ind_sel == {8{$past(ind_en_s)}});
  endproperty
  a_sel_all: assert property (p_sel_all) else $error("select bits split");

  // a digital reset restarts the loader with a single pulse
  property p_start;
    wr_rst |=> ##1 loader_start_o ##1 !loader_start_o;
  endproperty
  a_start: assert property (p_start) else $error("loader not restarted");

  // manual crossover acts only with auto crossover off and no override
  property p_mdix;
    (!crossover_override_bit && !eff_r.auto_x) |=> (mdix_o.force_x == $past(eff_r.man_x));
  endproperty
  a_mdix: assert property (p_mdix) else $error("manual crossover wrong");

  // auto crossover follows the strap while the override is clear
  property p_auto;
    !crossover_override_bit |=> (mdix_o.auto_en == $past(eff_r.auto_x));
  endproperty
  a_auto: assert property (p_auto) else $error("auto crossover wrong");

  // the override silences both crossover straps
  property p_override;
    crossover_override_bit |=> !mdix_o.auto_en && !mdix_o.force_x;
  endproperty
  a_override: assert property (p_override) else $error("override ignored");

  // a rising negotiation strap brings full capability defaults
  property p_an;
    $rose(eff_r.an) |=> phy_def_o.an_en && (phy_def_o.mode == `MODE_ALL_CAP);
  endproperty
  a_an: assert property (p_an) else $error("negotiation defaults wrong");

  // negotiation enable default tracks the effective strap once captured
  property p_an_bit;
    !pending_r |=> (phy_def_o.an_en == $past(eff_r.an));
  endproperty
  a_an_bit: assert property (p_an_bit) else $error("negotiation bit wrong");

  // with negotiation on, rate, duplex and both advert bits are set
  property p_an_adv;
    eff_r.an |=> phy_def_o.rate && phy_def_o.duplex &&
                 phy_def_o.adv_10f && phy_def_o.adv_10h;
  endproperty
  a_an_adv: assert property (p_an_adv) else $error("advert defaults wrong");

  // with negotiation off, rate, duplex and mode come from the ties
  property p_an_off;
    !eff_r.an |=> (phy_def_o.rate == SPEED_TIE) && (phy_def_o.duplex == DUPLEX_TIE) &&
                  (phy_def_o.mode == {1'b0, SPEED_TIE, DUPLEX_TIE});
  endproperty
  a_an_off: assert property (p_an_off) else $error("fixed rate defaults wrong");

  // the bus answer stands for one cycle only
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");

  // read data is zero outside the answer cycle
  property p_dat_idle;
    !wb_ack_o |-> (wb_dat_o == `WORD_ZERO);
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data leaked");

  // a read of the effective word answers next cycle with the effective straps
  property p_read_eff;
    (take && hit(wb_req_i.adr, `ADR_EFFECTIVE)) |=>
      wb_ack_o && (wb_dat_o == 32'($past(eff_r)));
  endproperty
  a_read_eff: assert property (p_read_eff) else $error("effective readback wrong");
endmodule

// ### strap_loader_model.sv
// behavioural eeprom loader that answers loader start pulses and bench kicks
`timescale 1ns/1ps
module strap_loader_model (
  input wire logic ref_clk,                       // system clock
  input wire logic rst_n,                         // async reset, active low
  input wire logic start_i,                       // loader start pulse from the block
  input wire logic go_i,                          // bench request for a load
  input wire logic present_i,                     // eeprom attached and programmed
  input wire logic [3:0] dly_i,                   // load latency in cycles, 1 or more
  input wire soft_strap_pkg::strap_set_t dat_i,   // values held in the eeprom
  output logic eeprom_valid_o,                    // eeprom valid towards the block
  output logic wr_o,                              // one cycle write pulse
  output soft_strap_pkg::strap_set_t dat_o        // loaded values, valid with wr_o
);
  import soft_strap_pkg::*;
  logic [3:0] cnt_r; // cycles left until the write
  assign eeprom_valid_o = present_i;
  // load starts only with an eeprom present; data toggles outside the write cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      wr_o <= 1'b0;
      dat_o <= '0;
    end else begin
      wr_o <= 1'b0;
      dat_o <= ~dat_o;
      if (cnt_r == 4'h1) begin
        wr_o <= 1'b1;
        dat_o <= dat_i;
        cnt_r <= 4'h0;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if ((start_i | go_i) & present_i) begin
        cnt_r <= dly_i;
      end
    end
  end
endmodule

// ### tb_soft_strap_latch.sv
// self-checking bench for the soft strap latch
`timescale 1ns/1ps
`include "soft_strap_consts.svh"
module tb_soft_strap_latch;
  import soft_strap_pkg::*;
  logic ref_clk, rst_n, ext_n, ind, ax, ov, present, go, lwr, valid, start, ack;
  logic [3:0] dly;
  strap_set_t d, lat, ldat, cfg;
  phy_default_t phy;
  mdix_ctrl_t mdix;
  wb_req_t req;
  logic [31:0] rdat, q;
  int n_errors, num_checks;
  soft_strap_latch dut (.ref_clk(ref_clk), .rst_n(rst_n), .external_reset_n(ext_n),
    .ind_en_pin(ind), .auto_x_pin(ax), .eeprom_valid_i(valid), .loader_wr_i(lwr),
    .loader_dat_i(ldat), .crossover_override_bit(ov), .wb_req_i(req), .cfg_o(cfg),
    .phy_def_o(phy), .mdix_o(mdix), .loader_start_o(start), .wb_ack_o(ack), .wb_dat_o(rdat));
  strap_loader_model model (.ref_clk(ref_clk), .rst_n(rst_n), .start_i(start), .go_i(go),
    .present_i(present), .dly_i(dly), .dat_i(d), .eeprom_valid_o(valid), .wr_o(lwr),
    .dat_o(ldat));
  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic wishbone single cycle, holds until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    q = rdat;
    req <= '0;
  endtask
  // phy defaults expected from the negotiation strap and the tied rate/duplex
  function automatic logic [31:0] phy_exp(input logic an);
    if (an) return 32'(8'hFF);
    return 32'({1'b0, `TIE_SPEED, `TIE_DUPLEX, ~`TIE_SPEED & `TIE_DUPLEX,
      ~`TIE_SPEED & ~`TIE_DUPLEX, 1'b0, `TIE_SPEED, `TIE_DUPLEX});
  endfunction
  // crossover control expected from the effective straps and override
  function automatic logic [31:0] mdix_exp(input strap_set_t s, input logic o);
    return 32'({~o & s.auto_x, ~o & ~s.auto_x & s.man_x});
  endfunction
  // settle, then compare all effective outputs with one strap set
  task automatic chk_all(input strap_set_t e);
    repeat (4) @(posedge ref_clk);
    #1;
    chk(32'(cfg), 32'(e));
    chk(32'(phy), phy_exp(e.an));
    chk(32'(mdix), mdix_exp(e, ov));
  endtask
  // verdict
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (4000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
  // main sequence
  initial begin
    void'($urandom(32'h7565));
    {rst_n, ext_n, ov, present, go, dly, d, req} = '0;
    ext_n = 1'b1;
    ind = 1'($urandom);
    ax = 1'($urandom);
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    lat = '{{8{ind}}, `TIE_IND_FUN, ax, `TIE_MAN_X, `TIE_AN};
    chk_all(lat);
    wb(1'b0, `ADR_LATCHED, `WORD_ZERO);
    chk(q, 32'(lat));
    wb(1'b0, 8'h10, `WORD_ZERO);
    chk(q, `WORD_ZERO);
    @(posedge ref_clk);
    ind <= ~ind;
    ax <= ~ax;
    chk_all(lat);
    // loader overrides, first one a forced manual crossover case
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      d <= (i == 0) ? 13'h0002 : strap_set_t'($urandom);
      ov <= (i == 0) ? 1'b0 : 1'($urandom);
      dly <= 4'(1 + $urandom % 8);
      present <= 1'b1;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk_all(d);
    end
    // reload with eeprom present keeps the loaded values
    wb(1'b1, `ADR_EEPROM_CMD, 32'h1 << `BIT_RELOAD);
    chk_all(d);
    wb(1'b0, `ADR_EEPROM_CMD, `WORD_ZERO);
    chk(q, 32'h1 << `BIT_EEPROM_OK);
    // reload without eeprom reverts to latched, not to the pins now
    present <= 1'b0;
    wb(1'b1, `ADR_EEPROM_CMD, 32'h1 << `BIT_RELOAD);
    chk_all(lat);
    wb(1'b0, `ADR_EFFECTIVE, `WORD_ZERO);
    chk(q, 32'(lat));
    // digital reset with eeprom present restarts the loader
    d <= strap_set_t'($urandom);
    present <= 1'b1;
    wb(1'b1, `ADR_RESET_CTRL, 32'h1 << `BIT_DIGITAL_RST);
    repeat (10) @(posedge ref_clk);
    chk_all(d);
    present <= 1'b0;
    wb(1'b1, `ADR_RESET_CTRL, 32'h1 << `BIT_DIGITAL_RST);
    chk_all(lat);
    wb(1'b0, `ADR_RESET_CTRL, `WORD_ZERO);
    chk(q, `WORD_ZERO);
    // pin reset re-latches the current pin levels
    ext_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ext_n <= 1'b1;
    lat = '{{8{ind}}, `TIE_IND_FUN, ax, `TIE_MAN_X, `TIE_AN};
    repeat (2) @(posedge ref_clk);
    chk_all(lat);
    summarize();
  end
endmodule
